// *** cfct_defs.vh ***
// cfct_defs.vh: register map, field positions, reset values and timer figures
// for the channel fault timing control block.
// assumes: included by bare name; definitions only.
`ifndef CFCT_DEFS_VH
`define CFCT_DEFS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define CFCT_ADDR_CFG     8'h00
`define CFCT_ADDR_MODE    8'h04
`define CFCT_ADDR_DIAG    8'h08
`define CFCT_ADDR_STATUS  8'h0c

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CFCT_RATIO_HI     11
`define CFCT_RATIO_LO     9
`define CFCT_OFFBL_HI     8
`define CFCT_OFFBL_LO     7
`define CFCT_ONBL_HI      6
`define CFCT_ONBL_LO      5
`define CFCT_CFG_RST      12'h140
`define CFCT_MODE_RST     6'h00
`define CFCT_DIAG_RST     12'h000
`define CFCT_CFG_MASK     12'hfe0
`define CFCT_NCH          6

// ****************************************************************
// timer figures: times in ns, retry count in timer ticks, divider in clock cycles
// ****************************************************************
`define CFCT_CLK_NS       4
`define CFCT_TICK_NS      250
`define CFCT_TICK_DIV     7'h3e
`define CFCT_BL_HI0_NS    6000
`define CFCT_BL_HI1_NS    12000
`define CFCT_BL_HI2_NS    24000
`define CFCT_BL_HI3_NS    48000
`define CFCT_BL_OFF0_NS   55000
`define CFCT_BL_OFF1_NS   81000
`define CFCT_BL_OFF2_NS   162000
`define CFCT_BL_OFF3_NS   325000
`define CFCT_FF_HI_NS     3000
`define CFCT_FF_OFF_NS    55000
`define CFCT_RETRY_TICKS  15'h7d00

`endif

// *** cfct_chan.v ***
// cfct_chan.v: one channel's blanking, fault filter and recovery sequencer.
// assumes: tick_in is a one-cycle strobe of the shared timer clock,
// retry_in a one-cycle strobe of the global retry timer.
`timescale 1ns/1ps
`default_nettype none
`include "cfct_defs.vh"

module cfct_chan (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       tick_in,
  input  wire       retry_in,
  input  wire       auto_in,
  input  wire       clr_in,
  input  wire       gate_cmd_in,
  input  wire       short_in,
  input  wire       sg_in,
  input  wire       ol_in,
  input  wire       sg_en_in,
  input  wire       ol_en_in,
  input  wire [1:0] on_bl_sel_in,
  input  wire [1:0] off_bl_sel_in,
  output reg        drive_out,
  output reg        fault_evt_out,
  output reg        off_type_out
);

  localparam [2:0] ST_BLANK = 3'b001;
  localparam [2:0] ST_WATCH = 3'b010;
  localparam [2:0] ST_FAULT = 3'b100;

  reg  [2:0]  state_ff;
  reg  [10:0] cnt_ff;
  reg         drive_cmd;
  reg         cond;

  // blanking length in ticks for the phase just entered
  function [10:0] blank_ticks;
    input       on;
    input [1:0] sel;
    reg   [31:0] ns;
    begin
      ns = 32'h0;
      case ({on, sel})
        3'b100:  ns = `CFCT_BL_HI0_NS;
        3'b101:  ns = `CFCT_BL_HI1_NS;
        3'b110:  ns = `CFCT_BL_HI2_NS;
        3'b111:  ns = `CFCT_BL_HI3_NS;
        3'b000:  ns = `CFCT_BL_OFF0_NS;
        3'b001:  ns = `CFCT_BL_OFF1_NS;
        3'b010:  ns = `CFCT_BL_OFF2_NS;
        default: ns = `CFCT_BL_OFF3_NS;
      endcase
      blank_ticks = (ns / `CFCT_TICK_NS) > 32'h0 ? ns_div(ns) : 11'h1;
    end
  endfunction

  // ns to ticks, truncated to counter width
  function [10:0] ns_div;
    input [31:0] ns;
    reg   [31:0] q;
    begin
      q = ns / `CFCT_TICK_NS;
      ns_div = q[10:0];
    end
  endfunction

  // drive request and the fault condition of the current phase
  always @* begin
    drive_cmd = gate_cmd_in & (state_ff != ST_FAULT);
    if (drive_out) begin
      cond = short_in;
    end else begin
      cond = (sg_in & sg_en_in) | (ol_in & ol_en_in);
    end
  end

  // sequencer: blank after each edge, then filter, then latch or retry
  always @(posedge clk_in) begin
    fault_evt_out <= 1'b0;
    if (!rst_n_in) begin
      state_ff     <= ST_BLANK;
      cnt_ff       <= blank_ticks(1'b0, 2'b10);
      drive_out    <= 1'b0;
      off_type_out <= 1'b0;
    end else begin
      case (state_ff)
        ST_BLANK, ST_WATCH: begin
          if (drive_cmd != drive_out) begin
            // new phase restarts blanking with that phase's time
            drive_out <= drive_cmd;
            state_ff  <= ST_BLANK;
            cnt_ff    <= blank_ticks(drive_cmd,
                           drive_cmd ? on_bl_sel_in : off_bl_sel_in);
          end else if (state_ff == ST_BLANK) begin
            if (cnt_ff == 11'h0) begin
              state_ff <= ST_WATCH;
            end else if (tick_in) begin
              cnt_ff <= cnt_ff - 11'h1;
            end
          end else if (!cond) begin
            cnt_ff <= 11'h0;                           // glitch shorter than filter
          end else if (cnt_ff >= (drive_out ? ns_div(`CFCT_FF_HI_NS)
                                            : ns_div(`CFCT_FF_OFF_NS))) begin
            state_ff      <= ST_FAULT;
            fault_evt_out <= 1'b1;
            off_type_out  <= ~drive_out;
            drive_out     <= 1'b0;
          end else if (tick_in) begin
            cnt_ff <= cnt_ff + 11'h1;
          end
        end
        ST_FAULT: begin
          // latch-off until cleared, or re-enable on the shared retry tick
          if (clr_in | (retry_in & auto_in)) begin
            state_ff <= ST_BLANK;
            cnt_ff   <= blank_ticks(1'b0, off_bl_sel_in);
          end
        end
        default: begin
          state_ff <= ST_BLANK;
          cnt_ff   <= 11'h0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** cfct_top.v ***
// cfct_top.v: six-channel fault timing control with an AHB-Lite register port.
// assumes: one 250 MHz clock, synchronous active-low reset, comparator
// inputs already synchronous to the clock, zero-wait single transfers.
//
// Function
// - three-bit ratio selects shorted-load level, 25 to 100 percent, reset 000.
// - two-bit on blanking selects 6, 12, 24 or 48 us, reset 10.
// - two-bit off blanking selects 55, 81, 162 or 325 us, reset 10.
// - fault accepted after persisting 3 us gate on, 55 us gate off.
// - auto-retry channels re-enable on shared 8 ms global retry timer.
// - off-state short-to-ground and open-load checks only when enabled.
// - reset stops timer clock, restores defaults and clears fault status.
`timescale 1ns/1ps
`default_nettype none
`include "cfct_defs.vh"

module cfct_top #(
  parameter [6:0]  TICK_DIV    = `CFCT_TICK_DIV,
  parameter [14:0] RETRY_TICKS = `CFCT_RETRY_TICKS
) (
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  input  wire [5:0]  gate_cmd_in,
  input  wire [5:0]  short_cmp_in,
  input  wire [5:0]  sg_cmp_in,
  input  wire [5:0]  ol_cmp_in,
  output reg  [5:0]  gate_out,
  output reg  [6:0]  threshold_ratio_pct_out,
  output reg  [5:0]  sg_diag_en_out,
  output reg  [5:0]  ol_diag_en_out,
  output reg         fault_flag_n_out
);

  // ****************************************************************
  // registers and wires
  // ****************************************************************
  reg  [11:0] cfg_ff;
  reg  [5:0]  recovery_mode_sel_ff;
  reg  [11:0] off_diag_enable_ff;
  reg  [5:0]  fault_sts_ff;
  reg  [5:0]  off_type_ff;
  reg  [6:0]  div_ff;
  reg         tick_ff;
  reg  [14:0] retry_cnt_ff;
  reg         retry_ff;
  reg         wr_pend_ff;
  reg  [7:0]  wr_addr_ff;
  reg  [5:0]  nxt_fault_sts;
  reg  [5:0]  sts_clr;
  wire [5:0]  drive;
  wire [5:0]  fault_evt;
  wire [5:0]  off_type;
  wire        addr_ok;
  wire [2:0]  short_threshold_ratio_sel;
  wire [1:0]  on_blanking_sel;
  wire [1:0]  off_blanking_sel;

  assign short_threshold_ratio_sel = cfg_ff[`CFCT_RATIO_HI:`CFCT_RATIO_LO];
  assign on_blanking_sel           = cfg_ff[`CFCT_ONBL_HI:`CFCT_ONBL_LO];
  assign off_blanking_sel          = cfg_ff[`CFCT_OFFBL_HI:`CFCT_OFFBL_LO];
  assign addr_ok = hsel_in & htrans_in[1] & hready_in;

  // ratio code to percent of the reference input
  function [6:0] ratio_pct;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    ratio_pct = 7'd25;
        3'h1:    ratio_pct = 7'd40;
        3'h2:    ratio_pct = 7'd50;
        3'h3:    ratio_pct = 7'd60;
        3'h4:    ratio_pct = 7'd70;
        3'h5:    ratio_pct = 7'd80;
        3'h6:    ratio_pct = 7'd90;
        default: ratio_pct = 7'd100;
      endcase
    end
  endfunction

  // ****************************************************************
  // timer clock and global retry timer
  // ****************************************************************

  // tick every TICK_DIV cycles; 62 cycles gives 248 ns, slightly fast
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      div_ff  <= 7'h0;
      tick_ff <= 1'b0;
    end else if (div_ff >= TICK_DIV - 7'h1) begin
      div_ff  <= 7'h0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 7'h1;
      tick_ff <= 1'b0;
    end
  end

  // shared retry period; one timer for all channels
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      retry_cnt_ff <= 15'h0;
      retry_ff     <= 1'b0;
    end else begin
      retry_ff <= 1'b0;
      if (tick_ff) begin
        if (retry_cnt_ff >= RETRY_TICKS - 15'h1) begin
          retry_cnt_ff <= 15'h0;
          retry_ff     <= 1'b1;
        end else begin
          retry_cnt_ff <= retry_cnt_ff + 15'h1;
        end
      end
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************

  // read data is fetched in the address phase so it stands in the data phase;
  // a read right behind a write to the same word sees the old value
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      hrdata_out    <= 32'h0;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_ff    <= 1'b0;
      wr_addr_ff    <= 8'h0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      // writes outside the decoded page are dropped, like reads
      wr_pend_ff    <= addr_ok & hwrite_in & (haddr_in[31:8] == 24'h0);
      wr_addr_ff    <= haddr_in[7:0];
      hrdata_out    <= 32'h0;
      if (addr_ok & ~hwrite_in & (haddr_in[31:8] == 24'h0)) begin
        case (haddr_in[7:0])
          `CFCT_ADDR_CFG:    hrdata_out <= {20'h0, cfg_ff};
          `CFCT_ADDR_MODE:   hrdata_out <= {26'h0, recovery_mode_sel_ff};
          `CFCT_ADDR_DIAG:   hrdata_out <= {20'h0, off_diag_enable_ff};
          `CFCT_ADDR_STATUS: hrdata_out <= {18'h0, off_type_ff, 2'h0, fault_sts_ff};
          default:           hrdata_out <= 32'h0;
        endcase
      end
    end
  end

  // configuration writes in the data phase; reserved bits ignored
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cfg_ff               <= `CFCT_CFG_RST;
      recovery_mode_sel_ff <= `CFCT_MODE_RST;
      off_diag_enable_ff   <= `CFCT_DIAG_RST;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        `CFCT_ADDR_CFG:  cfg_ff <= hwdata_in[11:0] & `CFCT_CFG_MASK;
        `CFCT_ADDR_MODE: recovery_mode_sel_ff <= hwdata_in[5:0];
        `CFCT_ADDR_DIAG: off_diag_enable_ff <= hwdata_in[11:0];
        default:         cfg_ff <= cfg_ff;
      endcase
    end
  end

  // ****************************************************************
  // fault status: sticky, write one to clear, a new event wins
  // ****************************************************************
  always @* begin
    sts_clr = 6'h0;
    if (wr_pend_ff & (wr_addr_ff == `CFCT_ADDR_STATUS)) begin
      sts_clr = hwdata_in[5:0];
    end
    nxt_fault_sts = (fault_sts_ff & ~sts_clr) | fault_evt;
  end

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      fault_sts_ff     <= 6'h0;
      off_type_ff      <= 6'h0;
      fault_flag_n_out <= 1'b1;
      gate_out         <= 6'h0;
      threshold_ratio_pct_out <= 7'd25;
      sg_diag_en_out   <= 6'h0;
      ol_diag_en_out   <= 6'h0;
    end else begin
      fault_sts_ff     <= nxt_fault_sts;
      off_type_ff      <= (off_type_ff & ~sts_clr) | (fault_evt & off_type);
      fault_flag_n_out <= ~|nxt_fault_sts;
      gate_out         <= drive;
      threshold_ratio_pct_out <= ratio_pct(short_threshold_ratio_sel);
      // diagnostic currents only on enabled channels whose gate is off
      sg_diag_en_out   <= ~drive & {off_diag_enable_ff[10], off_diag_enable_ff[8],
                           off_diag_enable_ff[6], off_diag_enable_ff[4],
                           off_diag_enable_ff[2], off_diag_enable_ff[0]};
      ol_diag_en_out   <= ~drive & {off_diag_enable_ff[11], off_diag_enable_ff[9],
                           off_diag_enable_ff[7], off_diag_enable_ff[5],
                           off_diag_enable_ff[3], off_diag_enable_ff[1]};
    end
  end

  // ****************************************************************
  // channels
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `CFCT_NCH; gi = gi + 1) begin : g_ch
      cfct_chan u_chan (
        .clk_in        (core_clk_in),
        .rst_n_in      (rst_n_in),
        .tick_in       (tick_ff),
        .retry_in      (retry_ff),
        .auto_in       (recovery_mode_sel_ff[gi]),
        .clr_in        (sts_clr[gi]),
        .gate_cmd_in   (gate_cmd_in[gi]),
        .short_in      (short_cmp_in[gi]),
        .sg_in         (sg_cmp_in[gi]),
        .ol_in         (ol_cmp_in[gi]),
        .sg_en_in      (off_diag_enable_ff[2*gi]),
        .ol_en_in      (off_diag_enable_ff[2*gi+1]),
        .on_bl_sel_in  (on_blanking_sel),
        .off_bl_sel_in (off_blanking_sel),
        .drive_out     (drive[gi]),
        .fault_evt_out (fault_evt[gi]),
        .off_type_out  (off_type[gi])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// *** cfct_top_monitor.sv ***
// cfct_top_monitor.sv: port-level checks for the fault timing block.
// assumes: bound into cfct_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cfct_top_monitor #(
  parameter [6:0] TICK_DIV = 7'd62
) (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [5:0]  gate_cmd_in,
  input wire logic [5:0]  short_cmp_in,
  input wire logic [5:0]  sg_cmp_in,
  input wire logic [5:0]  ol_cmp_in,
  input wire logic [5:0]  gate_out,
  input wire logic [6:0]  threshold_ratio_pct_out,
  input wire logic [5:0]  sg_diag_en_out,
  input wire logic [5:0]  ol_diag_en_out,
  input wire logic        fault_flag_n_out
);
  // ************************************
  // helper state
  // ************************************
  localparam logic [6:0] PCT [8] = '{7'd25, 7'd40, 7'd50, 7'd60, 7'd70, 7'd80, 7'd90, 7'd100};
  logic        cfg_dph_ff;
  logic        rd_dph_ff;
  logic [6:0]  exp_pct_ff;
  logic [15:0] hi_cnt_ff;
  logic [15:0] sc_cnt_ff;
  wire logic   aph = hsel_in & htrans_in[1] & hready_in & (haddr_in[31:8] == 24'h0);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // data-phase flags; run counters saturate so long runs never wrap
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cfg_dph_ff <= 1'b0;
      rd_dph_ff <= 1'b0;
      exp_pct_ff <= 7'd25;
      hi_cnt_ff <= 16'h0;
      sc_cnt_ff <= 16'h0;
    end else begin
      cfg_dph_ff <= aph & hwrite_in & (haddr_in[7:0] == 8'h00);
      rd_dph_ff <= aph & !hwrite_in & (haddr_in[7:0] <= 8'h0c);
      if (cfg_dph_ff) exp_pct_ff <= PCT[hwdata_in[11:9]];
      hi_cnt_ff <= gate_out[0] ? hi_cnt_ff + {15'h0, hi_cnt_ff != 16'hffff} : 16'h0;
      sc_cnt_ff <= short_cmp_in[0] ? sc_cnt_ff + {15'h0, sc_cnt_ff != 16'hffff} : 16'h0;
    end
  end
  // ************************************
  // assertions
  // ************************************
  a_reset_defaults: assert property (disable iff (1'b0) !rst_n_in |=>
    threshold_ratio_pct_out == 7'd25 && gate_out == 6'h0 && fault_flag_n_out
    && hrdata_out == 32'h0 && sg_diag_en_out == 6'h0) else $error("reset values wrong");
  a_bus_okay: assert property (hreadyout_out && !hresp_out) else $error("bus not ready or okay");
  a_read_idle: assert property (!rd_dph_ff |-> hrdata_out == 32'h0) else $error("stray read data");
  a_ratio_track: assert property (cfg_dph_ff ##1 !cfg_dph_ff |=>
    threshold_ratio_pct_out == exp_pct_ff) else $error("ratio percent wrong");
  a_gate_follow: assert property ((gate_out & ~$past(gate_cmd_in, 2)) == 6'h0)
    else $error("gate without request");
  a_diag_gate_off: assert property
    (((sg_diag_en_out | ol_diag_en_out) & gate_out & $past(gate_out)) == 6'h0)
    else $error("diag current while gate drives");
  a_short_filter: assert property ($fell(gate_out[0]) && $past(gate_cmd_in[0])
    && $past(gate_cmd_in[0], 2) |-> sc_cnt_ff >= 11 * TICK_DIV) else $error("filter too short");
  a_blank_hold: assert property ($fell(gate_out[0]) && $past(gate_cmd_in[0])
    && $past(gate_cmd_in[0], 2) |-> hi_cnt_ff >= 34 * TICK_DIV) else $error("blanking too short");
  a_flag_cause: assert property ($fell(fault_flag_n_out) |->
    ($past(short_cmp_in | sg_cmp_in | ol_cmp_in) != 6'h0)
    || ($past(short_cmp_in | sg_cmp_in | ol_cmp_in, 2) != 6'h0)) else $error("fault without cause");
  // main scenarios reached
  c_fault: cover property ($fell(fault_flag_n_out));
  c_retry: cover property ($rose(gate_out[0]) && $past(gate_cmd_in[0], 3));
  c_cfg_write: cover property (cfg_dph_ff);
endmodule
bind cfct_top cfct_top_monitor #(.TICK_DIV(TICK_DIV)) u_mon (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .gate_cmd_in(gate_cmd_in), .short_cmp_in(short_cmp_in), .sg_cmp_in(sg_cmp_in),
  .ol_cmp_in(ol_cmp_in), .gate_out(gate_out), .threshold_ratio_pct_out(threshold_ratio_pct_out),
  .sg_diag_en_out(sg_diag_en_out), .ol_diag_en_out(ol_diag_en_out),
  .fault_flag_n_out(fault_flag_n_out));
`default_nettype wire

// *** cfct_load_model.sv ***
// cfct_load_model.sv: drain comparators of six external switches.
// assumes: fault injections come from the bench, gates from the block.
`timescale 1ns/1ps
`default_nettype none
module cfct_load_model (
  input  wire logic [5:0] gate_in,
  input  wire logic [5:0] sg_en_in,
  input  wire logic [5:0] ol_en_in,
  input  wire logic [5:0] short_flt_in,
  input  wire logic [5:0] gnd_flt_in,
  input  wire logic [5:0] open_flt_in,
  output var  logic [5:0] short_cmp_out,
  output var  logic [5:0] sg_cmp_out,
  output var  logic [5:0] ol_cmp_out
);
  // ************************************
  // comparators
  // ************************************
  // a shorted load only shows while the gate conducts
  assign short_cmp_out = gate_in & short_flt_in;
  // without diag current the drain rests at bias, so no off-state trip
  assign sg_cmp_out = ~gate_in & sg_en_in & gnd_flt_in;
  assign ol_cmp_out = ~gate_in & ol_en_in & open_flt_in;
endmodule
`default_nettype wire

// *** tb_channel_fault_timing_control.sv ***
// tb_channel_fault_timing_control.sv: self-checking bench for cfct_top.
// assumes: cfct_load_model at the drain side, bus master in this file.
`timescale 1ns/1ps
`default_nettype none
`include "cfct_defs.vh"
module tb_channel_fault_timing_control;
  localparam int TD = 2;
  localparam int RT = 20;
  localparam int COND_NS [4] = '{6000, 12000, 24000, 48000};
  localparam int IDLE_NS [4] = '{55000, 81000, 162000, 325000};
  localparam int PCT [8] = '{25, 40, 50, 60, 70, 80, 90, 100};
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic [5:0]  cmd = 6'h0, fs = 6'h0, fg = 6'h0, fo = 6'h0;
  wire logic   hrdy, hresp, flag_n;
  wire logic [31:0] hrdata;
  wire logic [5:0]  gate, sc, sg, ol, sgen, olen;
  wire logic [6:0]  pct;
  int mdl [4];
  int error_cnt = 0, checked = 0;
  cfct_top #(.TICK_DIV(7'd2), .RETRY_TICKS(15'd20)) uut (.core_clk_in(clk), .rst_n_in(rst_n),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp), .gate_cmd_in(cmd), .short_cmp_in(sc), .sg_cmp_in(sg), .ol_cmp_in(ol),
    .gate_out(gate), .threshold_ratio_pct_out(pct), .sg_diag_en_out(sgen),
    .ol_diag_en_out(olen), .fault_flag_n_out(flag_n));
  cfct_load_model u_load (.gate_in(gate), .sg_en_in(sgen), .ol_en_in(olen), .short_flt_in(fs),
    .gnd_flt_in(fg), .open_flt_in(fo), .short_cmp_out(sc), .sg_cmp_out(sg), .ol_cmp_out(ol));
  always #2 clk = ~clk;
  // ************************************
  // tasks
  // ************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  // one single transfer; every step on a rising edge, read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (a == 32'h0) mdl[0] = d & 32'hfe0;
    if (a == 32'h4) mdl[1] = d & 32'h3f;
    if (a == 32'h8) mdl[2] = d & 32'hfff;
    if (a == 32'hc) mdl[3] = mdl[3] & ~d;
  endtask
  task automatic rd(input logic [31:0] a);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("register read", (a <= 32'hc) ? mdl[a >> 2] : 0, q);
  endtask
  // cycles until: 0 gate rises, 1 gate falls, 2 flag asserts
  task automatic span(input int w, input int ch, output int n);
    n = 0;
    while (n < 9000) begin
      @(negedge clk);
      if (w == 0 ? gate[ch] === 1'b1 : w == 1 ? gate[ch] === 1'b0 : flag_n === 1'b0) break;
      n++;
    end
    @(posedge clk);
    chk("span limit", 1, n < 9000);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    mdl = '{`CFCT_CFG_RST, 0, 0, 0};
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog well beyond the expected run of about 8k cycles
  initial begin
    #200000;
    error_cnt++;
    $display("watchdog expired");
    conclude();
  end
  // ************************************
  // test sequence
  // ************************************
  initial begin
    int n, b;
    logic [31:0] d;
    void'($urandom(50078));
    do_reset();
    for (int a = 0; a <= 16; a += 4) rd(a);
    chk("pct", 32'd25, pct);
    chk("flag", 32'h1, flag_n);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[11:9] = i[2:0];
      wr(`CFCT_ADDR_CFG, d);
      rd(`CFCT_ADDR_CFG);
      chk("pct", PCT[i], pct);
      wr(`CFCT_ADDR_MODE, $urandom);
      rd(`CFCT_ADDR_MODE);
      wr(`CFCT_ADDR_DIAG, $urandom);
      rd(`CFCT_ADDR_DIAG);
    end
    wr(32'h10, $urandom);
    rd(32'h10);
    wr(32'h100, $urandom);
    rd(`CFCT_ADDR_CFG);
    wr(`CFCT_ADDR_MODE, 0);
    wr(`CFCT_ADDR_DIAG, 0);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      wr(`CFCT_ADDR_CFG, s << 5);
      cmd[0] <= 1'b1;
      fs[0] <= 1'b1;
      span(0, 0, n);
      span(2, 0, n);
      b = COND_NS[s] / 250;
      chk("blank plus filter", 1, n >= (b + 10) * TD && n <= (b + 13) * TD + 6);
      mdl[3] = 32'h1;
      rd(`CFCT_ADDR_STATUS);
      cmd[0] <= 1'b0;
      fs[0] <= 1'b0;
      wr(`CFCT_ADDR_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk("flag", 32'h1, flag_n);
    end
    $display("test conducting faults done");
    fo[2] <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      // even passes trip short-to-ground, odd passes open load, on channel 1
      wr(`CFCT_ADDR_DIAG, s[0] ? 32'h8 : 32'h4);
      wr(`CFCT_ADDR_CFG, s << 7);
      cmd[1] <= 1'b1;
      span(0, 1, n);
      cmd[1] <= 1'b0;
      fg[1] <= ~s[0];
      fo[1] <= s[0];
      span(1, 1, n);
      span(2, 0, n);
      b = IDLE_NS[s] / 250;
      chk("idle blank plus filter", 1, n >= (b + 218) * TD && n <= (b + 221) * TD + 6);
      chk("sg enable", s[0] ? 32'h0 : 32'h2, sgen);
      chk("ol enable", s[0] ? 32'h2 : 32'h0, olen);
      mdl[3] = 32'h202;
      rd(`CFCT_ADDR_STATUS);
      fg[1] <= 1'b0;
      fo[1] <= 1'b0;
      wr(`CFCT_ADDR_STATUS, 32'h202);
    end
    fo[2] <= 1'b0;
    $display("test idle faults done");
    wr(`CFCT_ADDR_CFG, 32'h0);
    cmd[0] <= 1'b1;
    fs[0] <= 1'b1;
    span(2, 0, n);
    repeat (3 * RT * TD) @(posedge clk);
    chk("latched gate", 32'h0, gate[0]);
    wr(`CFCT_ADDR_MODE, 32'h1);
    span(0, 0, n);
    chk("retry span", 1, n <= (RT + 2) * TD + 8);
    cmd[0] <= 1'b0;
    fs[0] <= 1'b0;
    wr(`CFCT_ADDR_MODE, 32'h0);
    wr(`CFCT_ADDR_STATUS, 32'h3f3f);
    $display("test retry done");
    wr(`CFCT_ADDR_CFG, 32'hfe0);
    do_reset();
    rd(`CFCT_ADDR_CFG);
    chk("pct", 32'd25, pct);
    chk("gate", 32'h0, gate);
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
